//--- hdl/lpd_pkg.sv
package lpd_pkg;

  // ************************************************************
  // register byte offsets on APB
  // ************************************************************
  localparam logic [7:0] OFS_CTRL_A   = 8'h00;  // control_status_a
  localparam logic [7:0] OFS_CTRL_B   = 8'h04;  // control_status_b
  localparam logic [7:0] OFS_BUS_ADDR = 8'h08;
  localparam logic [7:0] OFS_BYTE_CNT = 8'h0C;
  localparam logic [7:0] OFS_PAGE_CNT = 8'h10;
  localparam logic [7:0] OFS_RAM_DATA = 8'h14;
  localparam logic [7:0] OFS_COL_CHAR = 8'h18;  // column [15:8], char buffer [7:0]
  localparam logic [7:0] OFS_SUM_PRN  = 8'h1C;  // checksum [15:8], printer data [7:0]

  // ************************************************************
  // control_status_a fields
  // ************************************************************
  localparam int CA_GO       = 0;
  localparam int CA_PARENB   = 1;
  localparam int CA_TEST     = 2;
  localparam int CA_VFLOAD   = 3;
  localparam int CA_ADRHI    = 4;   // two bits
  localparam int CA_INTENB   = 6;
  localparam int CA_DONE     = 7;
  localparam int CA_LOINIT   = 8;
  localparam int CA_RSTERR   = 9;
  localparam int CA_ONLINE   = 11;
  localparam int CA_UNDCHAR  = 13;
  localparam int CA_PAGEZERO = 14;
  localparam int CA_ERROR    = 15;

  // ************************************************************
  // control_status_b fields
  // ************************************************************
  localparam int CB_PAGESTEP  = 0;
  localparam int CB_DEMERR    = 1;
  localparam int CB_FORCEDERR = 2;
  localparam int CB_TESTTYPE  = 8;  // three bits
  localparam int CB_PARITY    = 12;
  localparam int CB_VALID     = 15;
  localparam logic [2:0] TT_NONE     = 3'h0;
  localparam logic [2:0] TT_PAGESTEP = 3'h6;
  localparam logic [2:0] TT_UNUSED   = 3'h7;

  // ************************************************************
  // mode bits {format load, test}
  // ************************************************************
  localparam logic [1:0] MODE_PRINT   = 2'h0;
  localparam logic [1:0] MODE_TEST    = 2'h1;
  localparam logic [1:0] MODE_VFLOAD  = 2'h2;
  localparam logic [1:0] MODE_RAMLOAD = 2'h3;

  // ************************************************************
  // translation word, sizes, timing
  // ************************************************************
  localparam int         RAM_W        = 12;
  localparam int         RAM_DEPTH    = 256;
  localparam int         RB_PRINTCMD  = 8;
  localparam int         RB_XLATE     = 9;
  localparam int         RB_UNDEF     = 11;
  localparam int         CNT_W        = 12;
  localparam logic [7:0] COL_LAST     = 8'h83;  // column 131
  localparam logic [7:0] SPACE_CODE   = 8'h20;
  localparam logic [7:0] DEL_CODE     = 8'h7F;
  localparam int         CLK_PERIOD_NS  = 4;
  localparam int         DEM_TIMEOUT_NS = 10000;
  localparam int         DEM_TIMEOUT_CYC = DEM_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [15:0] RST_WORD    = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_READ, ST_LATCH, ST_XLATE, ST_STEP, ST_STROBE, ST_WAITDEM
  } lpd_state_t;

endpackage

//--- hdl/lpd_xlate_ram.sv
`timescale 1ns/10ps
module lpd_xlate_ram #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 256
) (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrIndex,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdIndex,
  output logic      [WIDTH-1:0]         rdData
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } lpd_ram_state_t;

  lpd_ram_state_t s;
  lpd_ram_state_t next_s;

  always_comb begin
    next_s = s;
    if (wrEn) begin
      next_s.mem[wrIndex] = wrData;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // read is combinational so the lookup follows the address register at once
  assign rdData = s.mem[rdIndex];

endmodule

//--- hdl/lpd_print_path.sv
`timescale 1ns/10ps
module lpd_print_path
  import lpd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // host bus DMA master
  output logic             dmaBusRequest,
  input  wire logic        busGrant,
  output logic             busBusy,
  output logic             busReadTransfer,
  output logic      [17:0] memAddr,
  input  wire logic        memAck,
  input  wire logic [15:0] memData,
  output logic             level4InterruptRequest,
  // printer port
  input  wire logic        printerDemand,
  input  wire logic        printerTopOfForm,
  input  wire logic        printerOnLine,
  output logic      [7:0]  printerData,
  output logic             printerParity,
  output logic             printerStrobe
);

  typedef struct packed {
    lpd_state_t       st;
    logic             go;
    logic             parEn;
    logic             testMode;
    logic             vfLoad;
    logic             intEn;
    logic [1:0]       adrHi;
    logic             done;
    logic             pageZero;
    logic             undChar;
    logic             demErr;
    logic             forcedErr;
    logic [2:0]       testType;
    logic             validToggle;
    logic [15:0]      busAddr;
    logic [CNT_W-1:0] byteCnt;
    logic [CNT_W-1:0] pageCnt;
    logic [7:0]       colCnt;
    logic [7:0]       charBuf;
    logic [7:0]       ramAddr;
    logic [7:0]       checksum;
    logic             printCmd;
    logic             strobeFf;
    logic [11:0]      timer;
    logic             tofPrev;
    logic [7:0]       prnData;
    logic             prnParity;
    logic             prnStrobe;
    logic             dmaReq;
    logic             busy;
    logic             busRead;
    logic [17:0]      memAddr;
    logic             irq;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } lpd_core_state_t;

  localparam logic [11:0] TIMEOUT_LOAD = 12'(DEM_TIMEOUT_CYC);

  lpd_core_state_t s;
  lpd_core_state_t next_s;
  logic [RAM_W-1:0] ramQ;
  logic             ramWe;
  logic             apbWr;
  logic             errBefore;

  lpd_xlate_ram #(
    .WIDTH (RAM_W),
    .DEPTH (RAM_DEPTH)
  ) u_xlate_ram (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wrEn     (ramWe),
    .wrIndex  (s.ramAddr),
    .wrData   (pwdata[RAM_W-1:0]),
    .rdIndex  (s.ramAddr),
    .rdData   (ramQ)
  );

  // a write takes effect at the edge where pready is seen high
  assign apbWr = psel & penable & s.pready & pwrite;
  assign ramWe = apbWr & (paddr == OFS_RAM_DATA);

  always_comb begin
    logic [1:0]  mode;
    logic        demandIn;
    logic        pageDec;
    logic        mapped;
    logic [7:0]  outChar;
    logic [15:0] ctrlA;
    logic [15:0] ctrlB;
    logic [16:0] addrSum;
    mode      = {s.vfLoad, s.testMode};
    demandIn  = 1'b0;
    pageDec   = 1'b0;
    mapped    = 1'b0;
    outChar   = 8'h00;
    ctrlA     = RST_WORD;
    ctrlB     = RST_WORD;
    addrSum   = 17'h00000;
    next_s    = s;
    errBefore = s.demErr | s.forcedErr;

    // ************************************************************
    // APB slave: one wait state, reads captured with pready
    // ************************************************************
    ctrlA[CA_GO]        = s.go;
    ctrlA[CA_PARENB]    = s.parEn;
    ctrlA[CA_TEST]      = s.testMode;
    ctrlA[CA_VFLOAD]    = s.vfLoad;
    ctrlA[CA_ADRHI+:2]  = s.adrHi;
    ctrlA[CA_INTENB]    = s.intEn;
    ctrlA[CA_DONE]      = s.done;
    ctrlA[CA_ONLINE]    = printerOnLine;
    ctrlA[CA_UNDCHAR]   = s.undChar;
    ctrlA[CA_PAGEZERO]  = s.pageZero;
    ctrlA[CA_ERROR]     = errBefore;
    ctrlB[CB_DEMERR]    = s.demErr;
    ctrlB[CB_FORCEDERR] = s.forcedErr;
    ctrlB[CB_TESTTYPE+:3] = s.testType;
    ctrlB[CB_PARITY]    = s.prnParity;
    ctrlB[CB_VALID]     = s.validToggle;

    next_s.pready = psel & penable & ~s.pready;
    next_s.prdata = 32'h00000000;
    unique case (paddr)
      OFS_CTRL_A:   begin next_s.prdata[15:0] = ctrlA; mapped = 1'b1; end
      OFS_CTRL_B:   begin next_s.prdata[15:0] = ctrlB; mapped = 1'b1; end
      OFS_BUS_ADDR: begin next_s.prdata[15:0] = s.busAddr; mapped = 1'b1; end
      OFS_BYTE_CNT: begin next_s.prdata[CNT_W-1:0] = s.byteCnt; mapped = 1'b1; end
      OFS_PAGE_CNT: begin next_s.prdata[CNT_W-1:0] = s.pageCnt; mapped = 1'b1; end
      OFS_RAM_DATA: begin next_s.prdata[RAM_W-1:0] = ramQ; mapped = 1'b1; end
      OFS_COL_CHAR: begin next_s.prdata[15:0] = {s.colCnt, s.charBuf}; mapped = 1'b1; end
      OFS_SUM_PRN:  begin next_s.prdata[15:0] = {s.checksum, s.prnData}; mapped = 1'b1; end
      default:      begin mapped = 1'b0; end
    endcase
    if (!(psel & penable & ~s.pready) || pwrite) begin
      next_s.prdata = 32'h00000000;
    end
    next_s.pslverr = psel & penable & ~s.pready & ~mapped;

    if (apbWr) begin
      unique case (paddr)
        OFS_CTRL_A: begin
          next_s.irq = 1'b0;
          if (pwdata[CA_LOINIT]) begin
            next_s.go        = 1'b0;
            next_s.parEn     = 1'b0;
            next_s.testMode  = 1'b0;
            next_s.vfLoad    = 1'b0;
            next_s.intEn     = 1'b0;
            next_s.pageZero  = 1'b0;
            next_s.undChar   = 1'b0;
            next_s.demErr    = 1'b0;
            next_s.forcedErr = 1'b0;
            next_s.testType  = TT_NONE;
            next_s.colCnt    = 8'h00;
            next_s.busAddr   = 16'h0000;
            next_s.byteCnt   = '0;
            next_s.done      = printerOnLine;
          end else if (pwdata[CA_RSTERR]) begin
            next_s.demErr    = 1'b0;
            next_s.forcedErr = 1'b0;
            next_s.go        = 1'b0;
            next_s.done      = s.done | s.testMode | printerOnLine;
          end else begin
            next_s.go       = pwdata[CA_GO];
            next_s.parEn    = pwdata[CA_PARENB];
            next_s.testMode = pwdata[CA_TEST];
            next_s.vfLoad   = pwdata[CA_VFLOAD];
            next_s.adrHi    = pwdata[CA_ADRHI+:2];
            next_s.intEn    = pwdata[CA_INTENB];
            if (pwdata[CA_GO] && !s.go) begin
              next_s.checksum = 8'h00;
            end
          end
        end
        OFS_CTRL_B: begin
          next_s.testType = pwdata[CB_TESTTYPE+:3];
          if (pwdata[CB_TESTTYPE+:3] == TT_PAGESTEP) begin
            pageDec = pwdata[CB_PAGESTEP];
          end else if (pwdata[CB_TESTTYPE+:3] != TT_NONE
                       && pwdata[CB_TESTTYPE+:3] != TT_UNUSED) begin
            next_s.forcedErr = 1'b1;
            next_s.go        = 1'b0;
          end
        end
        OFS_BUS_ADDR: next_s.busAddr = pwdata[15:0];
        OFS_BYTE_CNT: begin
          next_s.byteCnt = pwdata[CNT_W-1:0];
          next_s.done    = 1'b0;
        end
        OFS_PAGE_CNT: next_s.pageCnt = pwdata[CNT_W-1:0];
        OFS_COL_CHAR: begin
          next_s.colCnt  = pwdata[15:8];
          next_s.charBuf = pwdata[7:0];
          next_s.ramAddr = pwdata[7:0];
        end
        default: begin
          next_s.pslverr = 1'b0;
        end
      endcase
    end

    // ************************************************************
    // page counter
    // ************************************************************
    next_s.tofPrev = printerTopOfForm;
    if (printerTopOfForm && !s.tofPrev && !s.testMode) begin
      pageDec = 1'b1;
    end
    if (pageDec) begin
      next_s.pageCnt = next_s.pageCnt - 12'h001;
      if (next_s.pageCnt == '0) begin
        next_s.pageZero = 1'b1;
        next_s.go       = 1'b0;
      end
    end

    // ************************************************************
    // DMA fetch, translate and strobe sequence
    // ************************************************************
    // test mode answers its own strobe, so no printer is needed
    demandIn = s.testMode ? ~s.strobeFf : printerDemand;
    unique case (s.st)
      ST_IDLE: begin
        // translation-RAM load is handled elsewhere; this path only serves the other modes
        if (next_s.go && demandIn && !s.strobeFf && mode != MODE_RAMLOAD) begin
          next_s.dmaReq = 1'b1;
          next_s.st     = ST_REQ;
        end
      end
      ST_REQ: begin
        if (busGrant) begin
          next_s.dmaReq  = 1'b0;
          next_s.busy    = 1'b1;
          next_s.busRead = 1'b1;
          next_s.memAddr = {s.adrHi, s.busAddr};
          next_s.st      = ST_READ;
        end
      end
      ST_READ: begin
        if (memAck) begin
          next_s.busRead = 1'b0;
          next_s.charBuf = s.busAddr[0] ? memData[15:8] : memData[7:0];
          next_s.st      = ST_LATCH;
        end
      end
      ST_LATCH: begin
        next_s.checksum = s.checksum + s.charBuf;
        next_s.ramAddr  = s.charBuf;
        next_s.st       = ST_XLATE;
      end
      ST_XLATE: begin
        // format load disables the RAM control bits entirely
        outChar = s.ramAddr;
        next_s.printCmd = 1'b0;
        if (mode != MODE_VFLOAD) begin
          if (ramQ[RB_XLATE]) begin
            outChar = ramQ[7:0];
          end
          if (ramQ[RB_UNDEF]) begin
            next_s.undChar = 1'b1;
            next_s.go      = 1'b0;
          end
          next_s.printCmd = ramQ[RB_PRINTCMD];
          if (!ramQ[RB_PRINTCMD]) begin
            if (outChar < SPACE_CODE || outChar == DEL_CODE) begin
              outChar = SPACE_CODE;
            end
            // wraps after the last column as the printer forces a new line
            next_s.colCnt = (s.colCnt == COL_LAST) ? 8'h00 : s.colCnt + 8'h01;
          end
        end
        next_s.prnData   = outChar;
        next_s.prnParity = ~^outChar;
        next_s.st        = ST_STEP;
      end
      ST_STEP: begin
        addrSum        = {1'b0, s.busAddr} + 17'h00001;
        next_s.busAddr = addrSum[15:0];
        next_s.adrHi   = s.adrHi + {1'b0, addrSum[16]};
        next_s.byteCnt = s.byteCnt + 12'h001;
        next_s.busy    = 1'b0;
        if (s.byteCnt == {CNT_W{1'b1}}) begin
          next_s.done = 1'b1;
          next_s.go   = 1'b0;
        end
        next_s.st = s.undChar ? ST_IDLE : ST_STROBE;
      end
      ST_STROBE: begin
        next_s.strobeFf    = 1'b1;
        next_s.prnStrobe   = ~s.testMode;
        next_s.validToggle = ~s.validToggle;
        next_s.timer       = TIMEOUT_LOAD;
        next_s.st          = ST_WAITDEM;
      end
      ST_WAITDEM: begin
        if (!demandIn) begin
          next_s.strobeFf  = 1'b0;
          next_s.prnStrobe = 1'b0;
          if (s.printCmd) begin
            next_s.colCnt = 8'h00;
          end
          next_s.st = ST_IDLE;
        end else if (s.timer == 12'h001) begin
          next_s.strobeFf  = 1'b0;
          next_s.prnStrobe = 1'b0;
          next_s.demErr    = 1'b1;
          next_s.go        = 1'b0;
          next_s.st        = ST_IDLE;
        end else begin
          next_s.timer = s.timer - 12'h001;
        end
      end
    endcase

    // ************************************************************
    // level-4 request on rising flags
    // ************************************************************
    // set after the clear above, so an event in the clearing write survives
    if (s.intEn && (((next_s.demErr | next_s.forcedErr) && !errBefore)
        || (next_s.pageZero && !s.pageZero) || (next_s.undChar && !s.undChar)
        || (s.st == ST_STEP && s.byteCnt == {CNT_W{1'b1}}))) begin
      next_s.irq = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s    <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata                 = s.prdata;
  assign pready                 = s.pready;
  assign pslverr                = s.pslverr;
  assign dmaBusRequest          = s.dmaReq;
  assign busBusy                = s.busy;
  assign busReadTransfer        = s.busRead;
  assign memAddr                = s.memAddr;
  assign level4InterruptRequest = s.irq;
  assign printerData            = s.prnData;
  assign printerParity          = s.prnParity;
  assign printerStrobe          = s.prnStrobe;

endmodule

//--- verification/lpd_print_path_props.sv
`timescale 1ns/10ps
// ****************************************
// handshake checks at the block's ports
// ****************************************
module lpd_print_path_props
  import lpd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        dmaBusRequest,
  input wire logic        busGrant,
  input wire logic        busBusy,
  input wire logic        busReadTransfer,
  input wire logic [17:0] memAddr,
  input wire logic        memAck,
  input wire logic        printerDemand,
  input wire logic        printerStrobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  int strobeLen;
  // a counter instead of a long repetition keeps the tools fast
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) strobeLen <= 0;
    else strobeLen <= printerStrobe ? strobeLen + 1 : 0;
  end
  property p_reqStart;
    $rose(dmaBusRequest) |-> $past(printerDemand) && !printerStrobe && !busBusy;
  endproperty
  a_reqStart: assert property (p_reqStart) else $error("request without demand");
  property p_reqHold;
    dmaBusRequest && !busGrant |=> dmaBusRequest;
  endproperty
  a_reqHold: assert property (p_reqHold) else $error("request dropped early");
  property p_grant;
    dmaBusRequest && busGrant |=> busBusy && busReadTransfer && !dmaBusRequest;
  endproperty
  a_grant: assert property (p_grant) else $error("no read after grant");
  property p_addrStable;
    busReadTransfer && !memAck |=> $stable(memAddr);
  endproperty
  a_addrStable: assert property (p_addrStable) else $error("address moved");
  property p_release;
    busReadTransfer && memAck |=> !busReadTransfer ##[1:4] !busBusy;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_strobeAfter;
    $rose(printerStrobe) |-> !busBusy && ($past(busBusy) || $past(busBusy, 2));
  endproperty
  a_strobeAfter: assert property (p_strobeAfter) else $error("strobe not after release");
  property p_strobeDrop;
    printerStrobe && !printerDemand |=> !printerStrobe;
  endproperty
  a_strobeDrop: assert property (p_strobeDrop) else $error("strobe kept");
  property p_timeout;
    strobeLen <= DEM_TIMEOUT_CYC + 2;
  endproperty
  a_timeout: assert property (p_timeout) else $error("strobe outlived timeout");
endmodule
bind lpd_print_path lpd_print_path_props chk (
  .core_clk(core_clk), .nrst(nrst), .dmaBusRequest(dmaBusRequest), .busGrant(busGrant),
  .busBusy(busBusy), .busReadTransfer(busReadTransfer), .memAddr(memAddr), .memAck(memAck),
  .printerDemand(printerDemand), .printerStrobe(printerStrobe)
);

//--- verification/lpd_printer_model.sv
`timescale 1ns/10ps
// ****************************************
// printer side of the demand/strobe port
// ****************************************
module lpd_printer_model (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       printerStrobe,
  input  wire logic [7:0] printerData,
  input  wire logic       stuck,
  input  wire logic [1:0] holdCycles,
  output logic            printerDemand
);
  logic [7:0] got[$];
  logic [1:0] dly;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      printerDemand <= 1'b1;
      dly <= 2'h0;
    end else if (printerStrobe && printerDemand && !stuck) begin
      // acknowledge takes a variable time, like a real mechanism
      if (dly >= holdCycles) begin
        printerDemand <= 1'b0;
        got.push_back(printerData);
        dly <= 2'h0;
      end else begin
        dly <= dly + 2'h1;
      end
    end else if (!printerDemand && !printerStrobe) begin
      printerDemand <= 1'b1;
    end
  end
endmodule

//--- verification/tb_line_printer_dma_print_path.sv
`timescale 1ns/10ps
module tb_line_printer_dma_print_path;
  import lpd_pkg::*;
  logic        core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, printerData, sum, b0, b1;
  logic [31:0] pwdata = 0, prdata, rv;
  logic        pready, pslverr, dmaBusRequest, busBusy, busReadTransfer, lastErr;
  logic        busGrant = 0, memAck = 0, printerTopOfForm = 0, printerOnLine = 1;
  logic        level4InterruptRequest, printerParity, printerStrobe, printerDemand, stuck = 0;
  logic [17:0] memAddr;
  logic [15:0] memData = 0, seed = 16'h0004;
  logic [15:0] mem [0:255];
  logic [11:0] xl [0:255];
  logic [7:0]  expq[$];
  int          mismatches = 0, n_compared = 0, col;
  always #2 core_clk = ~core_clk;
  lpd_print_path uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dmaBusRequest(dmaBusRequest), .busGrant(busGrant), .busBusy(busBusy),
    .busReadTransfer(busReadTransfer), .memAddr(memAddr), .memAck(memAck), .memData(memData),
    .level4InterruptRequest(level4InterruptRequest), .printerDemand(printerDemand),
    .printerTopOfForm(printerTopOfForm), .printerOnLine(printerOnLine),
    .printerData(printerData), .printerParity(printerParity), .printerStrobe(printerStrobe));
  lpd_printer_model prn (.core_clk(core_clk), .nrst(nrst), .printerStrobe(printerStrobe),
    .printerData(printerData), .stuck(stuck), .holdCycles(seed[1:0]),
    .printerDemand(printerDemand));
  // ****************************************
  // host memory: a released bus does not hold the word
  // ****************************************
  always @(posedge core_clk) begin
    busGrant <= dmaBusRequest && !busGrant;
    memAck <= busReadTransfer && !memAck;
    memData <= busReadTransfer ? mem[memAddr[8:1]] : ~memData;
  end
  initial begin
    #(CLK_PERIOD_NS * 40000);
    mismatches++;
    print_verdict;
  end
  // ****************************************
  // tasks and reference model
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    lastErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(rv & m, e, nm);
  endtask
  task automatic runWait;
    do begin
      apb(1'b0, OFS_CTRL_A, 32'h0);
    end while (rv[CA_GO] !== 1'b0);
    // go falls at the last step, before that byte's strobe handshake ends
    repeat (8) @(posedge core_clk);
  endtask
  task automatic tof;
    printerTopOfForm <= 1'b1;
    repeat (3) @(posedge core_clk);
    printerTopOfForm <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic model(input logic [7:0] b);
    logic [7:0] c;
    c = xl[b][RB_XLATE] ? xl[b][7:0] : b;
    if (!xl[b][RB_PRINTCMD] && (c < SPACE_CODE || c == DEL_CODE)) c = SPACE_CODE;
    expq.push_back(c);
    col = xl[b][RB_PRINTCMD] ? 0 : (col == 131 ? 0 : col + 1);
    sum = sum + b;
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 256; i++) begin
      xl[i] = 12'h000;
      mem[i] = 16'h0000;
    end
    mem[8'h80] = 16'h0A5A;
    mem[8'h81] = 16'h0141;
    seed = lfsr(lfsr(seed));
    mem[8'h82] = seed;
    {b1, b0} = seed;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdchk(OFS_CTRL_A, 32'hFFFFFFFF, 32'h0800, "ctrlA reset");
    for (int a = 4; a < 32; a += 4) rdchk(a[7:0], 32'hFFFFFFFF, 32'h0, "reset value");
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, lastErr}, 32'h1, "unmapped");
    apb(1'b1, OFS_COL_CHAR, 32'h41);
    apb(1'b1, OFS_RAM_DATA, 32'h261);
    xl[8'h41] = 12'h261;
    apb(1'b1, OFS_COL_CHAR, 32'h0A);
    apb(1'b1, OFS_RAM_DATA, 32'h10A);
    xl[8'h0A] = 12'h10A;
    apb(1'b1, OFS_COL_CHAR, 32'h0500);
    rdchk(OFS_COL_CHAR, 32'hFFFF, 32'h0500, "column write");
    col = 5;
    sum = 8'h00;
    model(8'h0A);
    model(8'h41);
    model(8'h01);
    // odd start address takes the high byte first
    apb(1'b1, OFS_BUS_ADDR, 32'h101);
    apb(1'b1, OFS_BYTE_CNT, 32'hFFD);
    apb(1'b1, OFS_PAGE_CNT, 32'h2);
    apb(1'b1, OFS_CTRL_A, 32'h41);
    runWait;
    chk(prn.got.size(), 32'h3, "printed count");
    foreach (expq[i]) chk({24'h0, prn.got[i]}, {24'h0, expq[i]}, "char");
    rdchk(OFS_CTRL_A, 32'h00FF, 32'h00C0, "done");
    chk({31'h0, level4InterruptRequest}, 32'h1, "irq done");
    rdchk(OFS_BUS_ADDR, 32'hFFFF, 32'h104, "address");
    rdchk(OFS_BYTE_CNT, 32'hFFF, 32'h0, "count");
    rdchk(OFS_COL_CHAR, 32'hFFFF, {16'h0, col[7:0], 8'h01}, "column");
    rdchk(OFS_SUM_PRN, 32'hFFFF, {16'h0, sum, 8'h20}, "checksum");
    chk({31'h0, printerParity}, {31'h0, ~^SPACE_CODE}, "parity");
    apb(1'b1, OFS_CTRL_A, 32'h0);
    chk({31'h0, level4InterruptRequest}, 32'h0, "irq clear");
    sum = b0 + b1;
    apb(1'b1, OFS_BYTE_CNT, 32'hFFE);
    apb(1'b1, OFS_CTRL_A, 32'h05);
    tof;
    runWait;
    chk(prn.got.size(), 32'h3, "test silent");
    rdchk(OFS_PAGE_CNT, 32'hFFF, 32'h2, "page in test");
    rdchk(OFS_SUM_PRN, 32'hFF00, {16'h0, sum, 8'h00}, "checksum cleared");
    chk({31'h0, level4InterruptRequest}, 32'h0, "irq masked");
    stuck <= 1'b1;
    // two bytes, so only the timeout can stop the run
    apb(1'b1, OFS_BYTE_CNT, 32'hFFE);
    apb(1'b1, OFS_CTRL_A, 32'h01);
    runWait;
    rdchk(OFS_CTRL_B, 32'h2, 32'h2, "demand timeout");
    rdchk(OFS_CTRL_A, 32'h8000, 32'h8000, "error flag");
    stuck <= 1'b0;
    apb(1'b1, OFS_CTRL_A, 32'h200);
    apb(1'b1, OFS_PAGE_CNT, 32'h3);
    apb(1'b1, OFS_CTRL_B, 32'h601);
    rdchk(OFS_PAGE_CNT, 32'hFFF, 32'h2, "page step");
    apb(1'b1, OFS_CTRL_A, 32'h40);
    tof;
    rdchk(OFS_PAGE_CNT, 32'hFFF, 32'h1, "top of form");
    tof;
    rdchk(OFS_CTRL_A, 32'h4000, 32'h4000, "page zero");
    chk({31'h0, level4InterruptRequest}, 32'h1, "irq page");
    apb(1'b1, OFS_CTRL_B, 32'h100);
    rdchk(OFS_CTRL_B, 32'h4, 32'h4, "forced error");
    print_verdict;
  end
endmodule
